// >>> hdl/crpc_clock_rate_ctrl.sv
/*
 * Clock-rate and PLL control: the clock-rate control register, the
 * per-peripheral cycle ticks, PLL divider and enable with a lock wait,
 * and the LED drive selection, all reached over classic Wishbone.
 * Assumes one 250 MHz clock standing for the oscillator and a
 * synchronous active-high reset; the PLL itself lies outside.
 */
// Function
// - Peripheral bits act only in double speed.
// - Double speed: clear gives 6, set 12.
// - Control bits fixed by position, bit7 to bit0.
// - Control register resets to all zeros.
// - Each LED selects 2, 6 or 10 mA.
// - LEDs map to port 3 pins 3,5,6,7.
`timescale 1ns/100ps

module crpc_clock_rate_ctrl #(
    parameter int unsigned LOCK_CYCLES = crpc_pkg::PLL_LOCK_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire crpc_pkg::crpc_wb_req_s wbReq,
    output crpc_pkg::crpc_wb_rsp_s      wbRsp,
    output crpc_pkg::crpc_tick_s        ticks,
    output crpc_pkg::crpc_pll_cfg_s     pllCfg,
    output logic                        pllLocked,
    output crpc_pkg::crpc_led_s         ledDrive,
    output logic [7:0]                  port3AltSel
);

    // Port 3 pin numbers that carry LED outputs 0 to 3.
    localparam int unsigned P3_PIN_LED0 = 3;
    localparam int unsigned P3_PIN_LED1 = 5;
    localparam int unsigned P3_PIN_LED2 = 6;
    localparam int unsigned P3_PIN_LED3 = 7;

    // Terminal value of the lock counter, sized to the counter.
    localparam int unsigned      CNT_W     = crpc_pkg::LOCK_CNT_W;
    localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYCLES - 1);

    // All state of the controller in one struct.
    typedef struct packed {
        logic                              ack;       // Bus answer strobe.
        logic [31:0]                       rdData;    // Read data for the answer.
        logic [7:0]                        clkCtrl;   // Clock-rate control register.
        logic [7:0]                        pll_divider_reg;    // PLL divider register.
        logic                              pllEn;     // PLL enable.
        logic                              locked;    // PLL lock indicator.
        logic [crpc_pkg::LOCK_CNT_W-1:0]   lockCnt;   // Lock wait counter.
        logic [7:0]                        ledCtrl;   // LED drive levels.
        logic [7:0]                        p3Alt;     // Port 3 alternate selects.
    } crpc_state_s;

    crpc_state_s state_q;  // Registered state.
    crpc_state_s state_d;  // Next state.
    logic [7:0]  sixSel;   // Per tick: one for 6 periods, zero for 12.
    logic        wbReqOn;  // A new bus request stands this cycle.
    logic        wbWrite;  // A new write to byte lane 0 stands this cycle.
    logic [7:0]  wbIdx;    // Register index decoded from the byte address.

    // Chooses 6 periods for one tick source from the global and local bits.
    function automatic logic crpc_six_periods(input logic dblSpeed,
                                              input logic localSel,
                                              input logic isCpu);
        if (isCpu) begin
            crpc_six_periods = dblSpeed;
        end else begin
            // Local bit matters only in double speed, clear means 6 periods.
            crpc_six_periods = dblSpeed & ~localSel;
        end
    endfunction

    // Reads one register by index; unmapped indices read as zero.
    function automatic logic [31:0] crpc_read_reg(input logic [7:0] idx,
                                                  input crpc_state_s st);
        crpc_read_reg = 32'h0000_0000;
        case (idx)
            crpc_pkg::IDX_CLK_CTRL: begin
                crpc_read_reg[7:0] = st.clkCtrl;
            end
            crpc_pkg::IDX_PLL_CTRL: begin
                crpc_read_reg[crpc_pkg::BIT_PLL_EN]     = st.pllEn;
                crpc_read_reg[crpc_pkg::BIT_PLL_LOCKED] = st.locked;
            end
            crpc_pkg::IDX_PLL_DIV: begin
                crpc_read_reg[7:0] = st.pll_divider_reg;
            end
            crpc_pkg::IDX_LED_CTRL: begin
                crpc_read_reg[7:0] = st.ledCtrl;
            end
            default: begin
                crpc_read_reg = 32'h0000_0000;
            end
        endcase
    endfunction

    // Mode select for each tick source, bit 0 being the CPU machine cycle.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            sixSel[i] = crpc_six_periods(state_q.clkCtrl[crpc_pkg::BIT_DOUBLE_SPD],
                                         state_q.clkCtrl[i], i == 0);
        end
    end

    // One period generator per tick, in register bit order.
    for (genvar g = 0; g < 8; g++) begin : gen_tick
        crpc_period_gen u_gen (
            .clk        (clk),
            .rst        (rst),
            .sixPeriods (sixSel[g]),
            .tick       (ticks[g])
        );
    end

    // Bus decode: a request is new while no answer is pending.
    assign wbReqOn = wbReq.cyc & wbReq.stb & ~state_q.ack;
    assign wbWrite = wbReqOn & wbReq.we & wbReq.sel[0];
    assign wbIdx   = wbReq.adr[9:2];

    // Next-state logic: bus writes, read answer, lock wait, LED mapping.
    always_comb begin
        state_d        = state_q;
        state_d.ack    = wbReqOn;
        state_d.rdData = 32'h0000_0000;

        // Read data is taken before this cycle's write lands.
        if (wbReqOn && !wbReq.we) begin
            state_d.rdData = crpc_read_reg(wbIdx, state_q);
        end

        // Writes land at the one edge that also raises the answer.
        if (wbWrite) begin
            case (wbIdx)
                crpc_pkg::IDX_CLK_CTRL: begin
                    state_d.clkCtrl = wbReq.dat[7:0];
                end
                crpc_pkg::IDX_PLL_CTRL: begin
                    state_d.pllEn = wbReq.dat[crpc_pkg::BIT_PLL_EN];
                end
                crpc_pkg::IDX_PLL_DIV: begin
                    state_d.pll_divider_reg = wbReq.dat[7:0];
                end
                crpc_pkg::IDX_LED_CTRL: begin
                    state_d.ledCtrl = wbReq.dat[7:0];
                end
                default: begin
                    state_d.ack = wbReqOn;  // Unmapped writes are acknowledged and dropped.
                end
            endcase
        end

        // Lock wait: a divider change or disable restarts it, because the
        // PLL must settle again before its output can be trusted.
        if (!state_d.pllEn || (wbWrite && wbIdx == crpc_pkg::IDX_PLL_DIV)) begin
            state_d.lockCnt = '0;
            state_d.locked  = 1'b0;
        end else if (!state_q.locked) begin
            if (state_q.lockCnt >= LOCK_LAST) begin
                state_d.locked = 1'b1;
            end else begin
                state_d.lockCnt = state_q.lockCnt + 1'b1;
            end
        end

        // A pin is handed to its LED function whenever the LED is driven.
        state_d.p3Alt              = 8'h00;
        state_d.p3Alt[P3_PIN_LED0] = |state_d.ledCtrl[1:0];
        state_d.p3Alt[P3_PIN_LED1] = |state_d.ledCtrl[3:2];
        state_d.p3Alt[P3_PIN_LED2] = |state_d.ledCtrl[5:4];
        state_d.p3Alt[P3_PIN_LED3] = |state_d.ledCtrl[7:6];
    end

    // State register; reset starts in standard speed with the PLL off.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q         <= '0;
            state_q.clkCtrl <= crpc_pkg::RST_CLK_CTRL;
            state_q.pll_divider_reg  <= crpc_pkg::RST_PLL_DIV;
            state_q.ledCtrl <= crpc_pkg::RST_LED_CTRL;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs come straight from state flip-flops.
    assign wbRsp.ack         = state_q.ack;
    assign wbRsp.dat         = state_q.rdData;
    assign pllCfg.enable     = state_q.pllEn;
    assign pllCfg.divRMinus1 = state_q.pll_divider_reg[crpc_pkg::DIV_R_MSB:crpc_pkg::DIV_R_LSB];
    assign pllCfg.divNMinus1 = state_q.pll_divider_reg[crpc_pkg::DIV_N_MSB:crpc_pkg::DIV_N_LSB];
    assign pllLocked         = state_q.locked;
    assign ledDrive          = crpc_pkg::crpc_led_s'(state_q.ledCtrl);
    assign port3AltSel       = state_q.p3Alt;

endmodule

// >>> hdl/crpc_period_gen.sv
/*
 * Period generator: emits a one-cycle tick every 6 or 12 block clock
 * cycles, chosen by an input level from the same clock domain.
 * Assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/100ps

module crpc_period_gen (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sixPeriods,
    output logic      tick
);

    // All state of the generator in one struct.
    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } crpc_gen_state_s;

    crpc_gen_state_s state_q;  // Registered state.
    crpc_gen_state_s state_d;  // Next state.
    logic [3:0]      lastCnt;  // Terminal count for the current mode.

    // Next-state logic; a count beyond the new limit wraps at once, so a
    // switch from 12 to 6 periods never stretches one cycle past 12.
    always_comb begin
        lastCnt = sixPeriods ? (crpc_pkg::PERIODS_SIX - 4'h1)
                             : (crpc_pkg::PERIODS_TWELVE - 4'h1);
        state_d = state_q;
        if (state_q.cnt >= lastCnt) begin
            state_d.cnt  = 4'h0;
            state_d.tick = 1'b1;
        end else begin
            state_d.cnt  = state_q.cnt + 4'h1;
            state_d.tick = 1'b0;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // The tick comes straight from a flip-flop.
    assign tick = state_q.tick;

endmodule

// >>> include/crpc_pkg.sv
/*
 * Package for the clock-rate and PLL control block: register indices,
 * field positions, reset values, timing constants and the packed structs
 * that carry the bus, tick, PLL and LED signal groups.
 * Assumes a 250 MHz block clock that stands for the oscillator clock.
 */
package crpc_pkg;

    // Block clock period in nanoseconds (250 MHz).
    localparam int unsigned CLK_PERIOD_NS = 4;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_CLK_CTRL = 8'h8F;  // Clock-rate control register.
    localparam logic [7:0] IDX_PLL_CTRL = 8'hA3;  // PLL enable and lock status.
    localparam logic [7:0] IDX_PLL_DIV  = 8'hA4;  // PLL divider register.
    localparam logic [7:0] IDX_LED_CTRL = 8'hF1;  // LED drive level register.

    // Reset values of the registers.
    localparam logic [7:0] RST_CLK_CTRL = 8'h00;
    localparam logic [7:0] RST_PLL_DIV  = 8'h00;
    localparam logic [7:0] RST_LED_CTRL = 8'h00;

    // Field positions in the clock-rate control register.
    localparam int unsigned BIT_TWO_WIRE   = 7;
    localparam int unsigned BIT_WATCHDOG   = 6;
    localparam int unsigned BIT_CNT_ARRAY  = 5;
    localparam int unsigned BIT_SERIAL     = 4;
    localparam int unsigned BIT_TIMER2     = 3;
    localparam int unsigned BIT_TIMER1     = 2;
    localparam int unsigned BIT_TIMER0     = 1;
    localparam int unsigned BIT_DOUBLE_SPD = 0;

    // Field positions in the PLL control register.
    localparam int unsigned BIT_PLL_EN     = 0;
    localparam int unsigned BIT_PLL_LOCKED = 1;

    // Divider register fields: R minus one high, N minus one low.
    localparam int unsigned DIV_R_MSB = 7;
    localparam int unsigned DIV_R_LSB = 4;
    localparam int unsigned DIV_N_MSB = 3;
    localparam int unsigned DIV_N_LSB = 0;

    // Oscillator periods per cycle in the two speed modes.
    localparam logic [3:0] PERIODS_SIX    = 4'h6;
    localparam logic [3:0] PERIODS_TWELVE = 4'hC;

    // PLL lock wait, as a time and as a count of block clock cycles.
    localparam int unsigned PLL_LOCK_NS  = 20000;
    localparam int unsigned PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOCK_CNT_W   = 16;

    // Drive level codes of one LED output.
    typedef enum logic [1:0] {
        LED_OFF   = 2'h0,
        LED_2MA   = 2'h1,
        LED_6MA   = 2'h2,
        LED_10MA  = 2'h3
    } crpc_led_level_e;

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } crpc_wb_req_s;

    // Classic Wishbone answer from this slave.
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } crpc_wb_rsp_s;

    // One-cycle clock enable ticks, ordered like the control register bits.
    typedef struct packed {
        logic twoWire;
        logic watchdog;
        logic cntArray;
        logic serial;
        logic timer2;
        logic timer1;
        logic timer0;
        logic cpu;
    } crpc_tick_s;

    // PLL settings handed to the analog PLL.
    typedef struct packed {
        logic       enable;
        logic [3:0] divRMinus1;
        logic [3:0] divNMinus1;
    } crpc_pll_cfg_s;

    // Drive levels of the four LED outputs, LED 3 in the top field.
    typedef struct packed {
        crpc_led_level_e led3;
        crpc_led_level_e led2;
        crpc_led_level_e led1;
        crpc_led_level_e led0;
    } crpc_led_s;

endpackage

// >>> test/crpc_clock_rate_ctrl_asserts.sv
/* Checker for the clock-rate control block: bus answer, tick spacing,
   PLL lock timing and LED pin use. Sees only the top module's ports. */
`timescale 1ns/100ps

module crpc_clock_rate_ctrl_asserts #(
    parameter int unsigned LOCK_CYCLES = crpc_pkg::PLL_LOCK_CYC
) (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire crpc_pkg::crpc_wb_req_s  wbReq,
    input wire crpc_pkg::crpc_wb_rsp_s  wbRsp,
    input wire crpc_pkg::crpc_tick_s    ticks,
    input wire crpc_pkg::crpc_pll_cfg_s pllCfg,
    input wire logic                    pllLocked,
    input wire crpc_pkg::crpc_led_s     ledDrive,
    input wire logic [7:0]              port3AltSel
);
    logic [4:0]  gap_q;     // Cycles since the last machine-cycle tick.
    logic [15:0] lockCnt_q; // Cycles the PLL has stayed enabled since its last restart.
    logic        divWr;     // A divider write is taken at this edge.
    assign divWr = wbReq.cyc && wbReq.stb && wbReq.we && !wbRsp.ack && wbReq.sel[0]
                   && (wbReq.adr[9:2] == crpc_pkg::IDX_PLL_DIV);
    // Helper counters; the lock count restarts on a divider write as the design does.
    always_ff @(posedge clk) begin
        gap_q <= (rst || ticks.cpu) ? 5'h00 : gap_q + 5'h01;
        if (rst || !pllCfg.enable || divWr) begin
            lockCnt_q <= 16'h0000;
        end else if (lockCnt_q != 16'hFFFF) begin
            lockCnt_q <= lockCnt_q + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_single: assert property (wbRsp.ack |=> !wbRsp.ack) else $error("ack too long");
    a_ack_answer: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
        else $error("request not answered next cycle");
    a_dat_idle: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0) else $error("dat not zero");
    a_cpu_min_gap: assert property (ticks.cpu |=> !ticks.cpu [*5])
        else $error("cpu ticks closer than six cycles");
    a_tmr_min_gap: assert property (ticks.timer0 |=> !ticks.timer0 [*5])
        else $error("timer0 ticks closer than six cycles");
    a_cpu_max_gap: assert property (gap_q <= 5'h0C)
        else $error("cpu tick gap above twelve cycles");
    a_lock_early: assert property ($rose(pllLocked) |-> lockCnt_q >= LOCK_CYCLES - 1)
        else $error("lock raised before the wait ran out");
    a_lock_late: assert property (lockCnt_q == LOCK_CYCLES + 3 |-> pllLocked)
        else $error("lock missing after the wait");
    a_lock_needs_en: assert property (pllLocked |-> pllCfg.enable)
        else $error("lock shown with PLL off");
    a_div_hold: assert property ($changed(pllCfg[7:0]) |-> $past(divWr))
        else $error("divider changed without a write");
    a_pin_unused: assert property (port3AltSel[4] == 1'h0 && port3AltSel[2:0] == 3'h0)
        else $error("non-LED pin handed over");
endmodule

bind crpc_clock_rate_ctrl crpc_clock_rate_ctrl_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) chk (
    .clk(clk), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .ticks(ticks), .pllCfg(pllCfg),
    .pllLocked(pllLocked), .ledDrive(ledDrive), .port3AltSel(port3AltSel));

// >>> test/test_crpc_clock_rate_ctrl.sv
/* Self-checking bench for the clock-rate control block.
   Assumes the package and the checker bind are compiled first. */
`timescale 1ns/100ps

module test_crpc_clock_rate_ctrl;
    typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} crpc_row_s;
    localparam int unsigned LOCK = 8; // Short lock wait keeps the run brief.
    localparam crpc_row_s ROWS [6] = '{'{crpc_pkg::IDX_CLK_CTRL, 8'hA5, 8'hA5},
        '{crpc_pkg::IDX_PLL_DIV, 8'h30, 8'h30}, '{crpc_pkg::IDX_PLL_DIV, 8'hF0, 8'hF0},
        '{crpc_pkg::IDX_LED_CTRL, 8'h1B, 8'h1B}, '{8'h10, 8'hFF, 8'h00},
        '{crpc_pkg::IDX_PLL_CTRL, 8'h00, 8'h00}};
    logic                    clk;
    logic                    rst;
    crpc_pkg::crpc_wb_req_s  wbReq;
    crpc_pkg::crpc_wb_rsp_s  wbRsp;
    crpc_pkg::crpc_tick_s    ticks;
    crpc_pkg::crpc_pll_cfg_s pllCfg;
    logic                    pllLocked;
    crpc_pkg::crpc_led_s     ledDrive;
    logic [7:0]              port3AltSel;
    logic [7:0]              rd;        // Last read data.
    int                      bad_count; // Mismatches seen.
    int                      cmp_count; // Comparisons made.

    crpc_clock_rate_ctrl #(.LOCK_CYCLES(LOCK)) dut (.clk(clk), .rst(rst), .wbReq(wbReq),
        .wbRsp(wbRsp), .ticks(ticks), .pllCfg(pllCfg), .pllLocked(pllLocked),
        .ledDrive(ledDrive), .port3AltSel(port3AltSel));

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compares a seen value against the expected one.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", name, ex, seen);
        end
    endtask

    // One classic Wishbone cycle; held until ack is sampled high, a hang is cut short.
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                       input logic s0);
        int n = 0;
        @(posedge clk);
        wbReq <= '{1'h1, 1'h1, we, {idx, 2'h0}, {3'h0, s0}, {24'h0, wd}};
        do begin
            @(posedge clk);
            n++;
        end while (wbRsp.ack !== 1'h1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            wrap_up();
        end
        rd = wbRsp.dat[7:0];
        wbReq <= '0;
    endtask

    // Measures the second full gap between ticks of bit k, skipping any switch-over gap.
    task automatic period(input int k, input int ex);
        int n = 0;
        for (int i = 0; i < 3; i++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (ticks[k] !== 1'h1 && n < 40);
        end
        check("tick period", n, ex);
    endtask

    // Free-running block clock.
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        rst = 1'h1;
        wbReq = '0;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        check("reset outputs", {pllCfg, pllLocked, ledDrive, port3AltSel}, 0);
        bus(1'h0, crpc_pkg::IDX_CLK_CTRL, 8'h00, 1'h1);
        check("ctrl reset", rd, crpc_pkg::RST_CLK_CTRL);
        // Ordinary register cases, write then read back.
        foreach (ROWS[i]) begin
            bus(1'h1, ROWS[i].idx, ROWS[i].wd, 1'h1);
            bus(1'h0, ROWS[i].idx, 8'h00, 1'h1);
            check("readback", rd, ROWS[i].ex);
        end
        // Standard speed: selection bits have no effect.
        bus(1'h1, crpc_pkg::IDX_CLK_CTRL, 8'hFE, 1'h1);
        for (int k = 0; k < 8; k++) period(k, crpc_pkg::PERIODS_TWELVE);
        // Double speed with all bits clear.
        bus(1'h1, crpc_pkg::IDX_CLK_CTRL, 8'h01, 1'h1);
        for (int k = 0; k < 8; k++) period(k, crpc_pkg::PERIODS_SIX);
        // One peripheral bit at a time picks twelve for its own tick only.
        for (int k = 1; k < 8; k++) begin
            bus(1'h1, crpc_pkg::IDX_CLK_CTRL, 8'h01 | (8'h01 << k), 1'h1);
            period(k, crpc_pkg::PERIODS_TWELVE);
            period((k % 7) + 1, crpc_pkg::PERIODS_SIX);
        end
        // A write without its byte lane is ignored.
        bus(1'h1, crpc_pkg::IDX_CLK_CTRL, 8'h00, 1'h0);
        bus(1'h0, crpc_pkg::IDX_CLK_CTRL, 8'h00, 1'h1);
        check("lane off", rd, 8'h81);
        // PLL: divider fields, lock wait, lock dropped by a divider write.
        bus(1'h1, crpc_pkg::IDX_PLL_DIV, 8'h72, 1'h1);
        check("divider", pllCfg[7:0], 8'h72);
        bus(1'h1, crpc_pkg::IDX_PLL_CTRL, 8'h01, 1'h1);
        for (int i = 0; i < 20 && rd[1] !== 1'h1; i++) bus(1'h0, crpc_pkg::IDX_PLL_CTRL, 8'h00, 1'h1);
        check("pll ctrl", rd, 8'h03);
        // A new divider drops the lock at once while the PLL stays enabled.
        bus(1'h1, crpc_pkg::IDX_PLL_DIV, 8'hB9, 1'h1);
        check("relock", {pllLocked, pllCfg}, {1'h0, 1'h1, 8'hB9});
        // LED levels and the pins they claim.
        bus(1'h1, crpc_pkg::IDX_LED_CTRL, 8'hE4, 1'h1);
        repeat (2) @(posedge clk);
        check("led pins", {ledDrive, port3AltSel}, 16'hE4E0);
        bus(1'h1, crpc_pkg::IDX_LED_CTRL, 8'h1B, 1'h1);
        repeat (2) @(posedge clk);
        check("led pins", {ledDrive, port3AltSel}, 16'h1B68);
        // Reset in mid-run clears everything again.
        rst <= 1'h1;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        bus(1'h0, crpc_pkg::IDX_CLK_CTRL, 8'h00, 1'h1);
        check("ctrl again", {rd, ledDrive, pllCfg}, 0);
        wrap_up();
    end
endmodule
